// ===== verilog/dps_device.sv
`timescale 1ns/100ps
// ****************************************
// transmit data buffer
// ****************************************
module dps_fifo #(
	parameter int W = 21,
	parameter int D = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [W-1:0] inData,
	// drain side
	output logic outValid,
	input wire logic outReady,
	output logic [W-1:0] outData
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_q [D];
	logic [AW:0] wrPtr_q;
	logic [AW:0] rdPtr_q;
	logic push;
	logic pop;
	// full when pointers differ only in wrap bit
	assign inReady = !(wrPtr_q[AW] != rdPtr_q[AW] && wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
	assign outValid = wrPtr_q != rdPtr_q;
	assign outData = mem_q[rdPtr_q[AW-1:0]];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	// storage entries
	for (genvar e = 0; e < D; e++) begin : g_ent
		always_ff @(posedge clk) begin
			if (push && wrPtr_q[AW-1:0] == AW'(e)) begin
				mem_q[e] <= inData;
			end
		end
	end
	// pointers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			if (push) wrPtr_q <= wrPtr_q + 1'b1;
			if (pop) rdPtr_q <= rdPtr_q + 1'b1;
		end
	end
endmodule // dps_fifo

// ****************************************
// port select and control, device end
// ****************************************
module dps_device import dps_pkg::*; (
	// register bus and request lines
	dps_if.dev bus,
	// receive side of pipe buffers
	input wire logic rxPktValid,
	input wire logic [3:0] rxPktPipe,
	input wire logic [LEN_W-1:0] rxPktLen,
	input wire logic [15:0] rxWord,
	output logic [3:0] bufRdPipe,
	output logic [LEN_W-2:0] bufRdAddr,
	// pipe configuration
	input wire logic [NPIPE-1:0] pipeTx,
	input wire logic [NPIPE-1:0] pipeFreeze,
	// transmit data stream
	output logic txValid,
	input wire logic txReady,
	output logic [3:0] txPipe,
	output logic [15:0] txData,
	output logic txTwoBytes,
	// buffer hand-over
	output logic commitValid,
	output logic [3:0] commitPipe,
	output logic [LEN_W-1:0] commitLen,
	output logic commitZlp
);
	logic clk;
	logic rst_n;
	logic [15:0] sel_q [NPORT];
	logic [LEN_W-1:0] len_q [NPIPE];
	logic [LEN_W-1:0] orig_q [NPIPE];
	logic [LEN_W-1:0] ptr_q [NPIPE];
	logic [LEN_W-1:0] wcnt_q [NPIPE];
	logic [NPIPE-1:0] zlp_q;
	logic [NPORT-1:0] selWr, ctrlWr, dataWr, dataRd, pipeOk, port_ready, isTx;
	logic [3:0] idx [NPORT];
	logic [LEN_W-1:0] step [NPORT];
	logic fifoInReady, fifoOutValid, fifoPop;
	logic [FIFO_W-1:0] fifoInData, fifoOutData;
	logic fifoPush;
	logic [15:0] regVal;
	logic [15:0] wrWord;
	logic [1:0] rdPort;
	logic rdPend_q, rdData_q, rdOdd_q, rdWide_q, rdBig_q;
	logic [15:0] regVal_q;
	logic [15:0] busRdata_q;
	logic busRvalid_q;
	logic [1:0] dmaReqN_q;

	assign clk = bus.clk;
	assign rst_n = bus.rst_n;
	assign bus.busRdata = busRdata_q;
	assign bus.busRvalid = busRvalid_q;
	assign bus.dmaReqN = dmaReqN_q;

	// ****************************************
	// address decode and per-port status
	// ****************************************
	always_comb begin
		for (int p = 0; p < NPORT; p++) begin
			selWr[p] = bus.busWr && bus.busAddr == SEL_ADDR[p];
			ctrlWr[p] = bus.busWr && bus.busAddr == CTRL_ADDR[p];
			dataWr[p] = bus.busWr && bus.busAddr == DATA_ADDR[p];
			dataRd[p] = bus.busRd && bus.busAddr == DATA_ADDR[p];
			pipeOk[p] = sel_q[p][3:0] != PIPE_NONE && sel_q[p][3:0] <= PIPE_MAX;
			idx[p] = pipeOk[p] ? sel_q[p][3:0] - 4'h1 : 4'h0;
			isTx[p] = pipeTx[idx[p]];
			step[p] = sel_q[p][SEL_MBW] ? STEP_HALF : STEP_BYTE;
			port_ready[p] = pipeOk[p] && (isTx[p] ? fifoInReady
				: (ptr_q[idx[p]] < orig_q[idx[p]] || zlp_q[idx[p]]));
		end
	end

	// select registers, rewind bit never stored
	always_ff @(posedge clk) begin
		for (int p = 0; p < NPORT; p++) begin
			if (!rst_n) begin
				sel_q[p] <= SEL_RESET;
			end else if (selWr[p]) begin
				sel_q[p] <= bus.busWdata & SEL_MASK[p] & ~(16'h0001 << SEL_REW);
			end
		end
	end

	// ****************************************
	// per-pipe buffer state
	// ****************************************
	for (genvar k = 0; k < NPIPE; k++) begin : g_pipe
		logic rdEv, wrEv, rewEv, clrEv, bvalEv, read_count_mode, auto_clear_enable, done, autoClr;
		logic [LEN_W-1:0] stp, wstp, newPtr;
		always_comb begin
			rdEv = 1'b0;
			wrEv = 1'b0;
			rewEv = 1'b0;
			clrEv = 1'b0;
			bvalEv = 1'b0;
			read_count_mode = 1'b0;
			auto_clear_enable = 1'b0;
			stp = STEP_BYTE;
			wstp = STEP_BYTE;
			for (int p = 0; p < NPORT; p++) begin
				if (pipeOk[p] && idx[p] == 4'(k)) begin
					rdEv = rdEv | (dataRd[p] && !pipeTx[k]);
					wrEv = wrEv | (dataWr[p] && port_ready[p] && pipeTx[k]);
					rewEv = rewEv | (selWr[p] && bus.busWdata[SEL_REW]
						&& bus.busWdata[3:0] == sel_q[p][3:0] && !pipeTx[k]);
					clrEv = clrEv | (ctrlWr[p] && bus.busWdata[CTRL_BUFFER_CLEAR]);
					bvalEv = bvalEv | (ctrlWr[p] && bus.busWdata[CTRL_BUFFER_VALID] && pipeTx[k]);
					if (dataRd[p]) stp = step[p];
					if (dataWr[p]) wstp = step[p];
					read_count_mode = sel_q[p][SEL_READ_COUNT_MODE];
					auto_clear_enable = sel_q[p][SEL_AUTO_CLEAR_ENABLE];
				end
			end
		end
		assign newPtr = ptr_q[k] + stp;
		assign done = newPtr >= orig_q[k];
		assign autoClr = rdEv && done && pipeFreeze[k] && auto_clear_enable;

		// position and length; arrival beats clear beats rewind beats read
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				len_q[k] <= '0;
				orig_q[k] <= '0;
				ptr_q[k] <= '0;
				zlp_q[k] <= 1'b0;
			end else if (rxPktValid && rxPktPipe == 4'(k + 1)) begin
				len_q[k] <= rxPktLen;
				orig_q[k] <= rxPktLen;
				ptr_q[k] <= '0;
				zlp_q[k] <= rxPktLen == '0 && len_q[k] == '0 && !auto_clear_enable;
			end else if (clrEv || autoClr) begin
				len_q[k] <= '0;
				orig_q[k] <= '0;
				ptr_q[k] <= '0;
				zlp_q[k] <= 1'b0;
			end else if (rewEv) begin
				ptr_q[k] <= '0;
				len_q[k] <= orig_q[k];
			end else if (rdEv) begin
				ptr_q[k] <= newPtr;
				if (read_count_mode) begin
					len_q[k] <= len_q[k] > stp ? len_q[k] - stp : '0;
				end else if (done && !pipeFreeze[k]) begin
					len_q[k] <= '0;
				end
			end
		end

		// bytes written since last hand-over
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				wcnt_q[k] <= '0;
			end else if (clrEv || bvalEv) begin
				wcnt_q[k] <= '0;
			end else if (wrEv) begin
				wcnt_q[k] <= wcnt_q[k] + wstp;
			end
		end
	end

	// ****************************************
	// hand-over of written buffers
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			commitValid <= 1'b0;
			commitPipe <= PIPE_NONE;
			commitLen <= '0;
			commitZlp <= 1'b0;
		end else begin
			commitValid <= 1'b0;
			for (int p = 0; p < NPORT; p++) begin
				if (ctrlWr[p] && bus.busWdata[CTRL_BUFFER_VALID] && pipeOk[p] && isTx[p]) begin
					commitValid <= 1'b1;
					commitPipe <= sel_q[p][3:0];
					commitLen <= bus.busWdata[CTRL_BUFFER_CLEAR] ? '0 : wcnt_q[idx[p]];
					commitZlp <= bus.busWdata[CTRL_BUFFER_CLEAR] || wcnt_q[idx[p]] == '0;
				end
			end
		end
	end

	// ****************************************
	// transmit data path through buffer
	// ****************************************
	always_comb begin
		fifoPush = 1'b0;
		fifoInData = '0;
		wrWord = bus.busWdata;
		for (int p = 0; p < NPORT; p++) begin
			if (dataWr[p] && port_ready[p] && isTx[p]) begin
				fifoPush = 1'b1;
				wrWord = sel_q[p][SEL_MBW] && sel_q[p][SEL_BYTE_ORDER_SEL]
					? {bus.busWdata[7:0], bus.busWdata[15:8]} : bus.busWdata;
				fifoInData = {sel_q[p][3:0], wrWord, sel_q[p][SEL_MBW]};
			end
		end
	end

	dps_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.inValid(fifoPush),
		.inReady(fifoInReady),
		.inData(fifoInData),
		.outValid(fifoOutValid),
		.outReady(fifoPop),
		.outData(fifoOutData)
	);

	assign fifoPop = fifoOutValid && (!txValid || txReady);

	// output stage of the stream
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txValid <= 1'b0;
			txPipe <= PIPE_NONE;
			txData <= '0;
			txTwoBytes <= 1'b0;
		end else if (!txValid || txReady) begin
			txValid <= fifoOutValid;
			{txPipe, txData, txTwoBytes} <= fifoOutData;
		end
	end

	// ****************************************
	// register reads, answer two cycles on
	// ****************************************
	always_comb begin
		regVal = 16'h0000;
		rdPort = 2'd0;
		for (int p = 0; p < NPORT; p++) begin
			if (bus.busAddr == SEL_ADDR[p]) regVal = sel_q[p];
			if (bus.busAddr == CTRL_ADDR[p]) begin
				regVal = {2'b00, port_ready[p], 1'b0, pipeOk[p] ? len_q[idx[p]] : 12'h000};
			end
			if (bus.busAddr == DATA_ADDR[p]) rdPort = 2'(p);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdPend_q <= 1'b0;
			rdData_q <= 1'b0;
			rdOdd_q <= 1'b0;
			rdWide_q <= 1'b0;
			rdBig_q <= 1'b0;
			regVal_q <= '0;
			bufRdPipe <= PIPE_NONE;
			bufRdAddr <= '0;
			busRdata_q <= '0;
			busRvalid_q <= 1'b0;
		end else begin
			rdPend_q <= bus.busRd;
			rdData_q <= |dataRd;
			regVal_q <= regVal;
			if (|dataRd) begin
				bufRdPipe <= sel_q[rdPort][3:0];
				bufRdAddr <= ptr_q[idx[rdPort]][LEN_W-1:1];
				rdOdd_q <= ptr_q[idx[rdPort]][0];
				rdWide_q <= sel_q[rdPort][SEL_MBW];
				rdBig_q <= sel_q[rdPort][SEL_BYTE_ORDER_SEL];
			end
			busRvalid_q <= rdPend_q;
			if (rdPend_q) begin
				if (!rdData_q) begin
					busRdata_q <= regVal_q;
				end else if (rdWide_q) begin
					busRdata_q <= rdBig_q ? {rxWord[7:0], rxWord[15:8]} : rxWord;
				end else begin
					busRdata_q <= {8'h00, rdOdd_q ? rxWord[15:8] : rxWord[7:0]};
				end
			end
		end
	end

	// ****************************************
	// dma request lines, active low
	// ****************************************
	always_ff @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			if (!rst_n) begin
				dmaReqN_q[i] <= 1'b1;
			end else begin
				dmaReqN_q[i] <= !(sel_q[i + 1][SEL_DMA_REQUEST_ENABLE] && pipeOk[i + 1] && port_ready[i + 1]);
			end
		end
	end
endmodule // dps_device

// ===== verilog/dps_pkg.sv
// Overview of operation
// - count mode 0: length cleared after all read
// - count mode 1: length decremented on reads
// - decrement one per byte, two per halfword
// - freeze-on-read requires count mode 0
// - rewind restarts reading at first data
// - rewind bit clears itself, reads zero
// - no rewind with pipe change; ready first
// - no rewind on short packet under freeze
// - auto clear after empty packet or freeze
// - auto clear off when ready irq mode
// - request enable gates the request output
// - enable after pipe write, clear before change
// - width bit: 0 byte, 1 halfword
// - order bit: 0 little, 1 big endian
// - pipe code routes port; 0 none, 1-9
// - read selection back until it matches; host reads back once, flags mismatch
// - one pipe on one port only
// - pipe change keeps access position
// - buffer valid hands buffer to transmit
// - buffer clear empties buffer, reads zero
// - port ready flag shows access allowed
// - control word shows received length
// - valid plus clear sends empty packet
package dps_pkg;
	localparam int NPORT = 3;
	localparam int NPIPE = 9;
	localparam int LEN_W = 12;
	localparam int ADDR_W = 7;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_W = 21;
	// register byte addresses, index 0 cpu port, 1 and 2 dma ports
	localparam logic [6:0] CPU_SEL = 7'h20;
	localparam logic [6:0] DMA0_SEL = 7'h28;
	localparam logic [6:0] DMA1_SEL = 7'h2C;
	localparam logic [6:0] CPU_CTRL = 7'h22;
	localparam logic [6:0] DMA0_CTRL = 7'h2A;
	localparam logic [6:0] DMA1_CTRL = 7'h2E;
	localparam logic [6:0] CPU_DATA = 7'h14;
	localparam logic [6:0] DMA0_DATA = 7'h18;
	localparam logic [6:0] DMA1_DATA = 7'h1C;
	localparam logic [2:0][6:0] SEL_ADDR = {DMA1_SEL, DMA0_SEL, CPU_SEL};
	localparam logic [2:0][6:0] CTRL_ADDR = {DMA1_CTRL, DMA0_CTRL, CPU_CTRL};
	localparam logic [2:0][6:0] DATA_ADDR = {DMA1_DATA, DMA0_DATA, CPU_DATA};
	// select word fields
	localparam int SEL_READ_COUNT_MODE = 15;
	localparam int SEL_REW = 14;
	localparam int SEL_AUTO_CLEAR_ENABLE = 13;
	localparam int SEL_DMA_REQUEST_ENABLE = 12;
	localparam int SEL_MBW = 10;
	localparam int SEL_BYTE_ORDER_SEL = 8;
	localparam logic [15:0] SEL_RESET = 16'h0000;
	localparam logic [15:0] DMA_SEL_MASK = 16'hF50F;
	localparam logic [15:0] CPU_SEL_MASK = 16'hC50F;
	localparam logic [2:0][15:0] SEL_MASK = {DMA_SEL_MASK, DMA_SEL_MASK, CPU_SEL_MASK};
	localparam logic [3:0] PIPE_NONE = 4'h0;
	localparam logic [3:0] PIPE_MAX = 4'h9;
	// control word fields
	localparam int CTRL_BUFFER_VALID = 15;
	localparam int CTRL_BUFFER_CLEAR = 14;
	localparam int CTRL_PORT_READY = 13;
	localparam logic [LEN_W-1:0] STEP_BYTE = 12'h001;
	localparam logic [LEN_W-1:0] STEP_HALF = 12'h002;
endpackage

// ===== verilog/dps_if.sv
`timescale 1ns/100ps
interface dps_if (
	input wire logic clk,
	input wire logic rst_n
);
	logic [6:0] busAddr;
	logic busWr;
	logic busRd;
	logic [15:0] busWdata;
	logic [15:0] busRdata;
	logic busRvalid;
	logic [1:0] dmaReqN;
	modport dev (input clk, rst_n, busAddr, busWr, busRd, busWdata,
		output busRdata, busRvalid, dmaReqN);
	modport host (input clk, rst_n, busRdata, busRvalid, dmaReqN,
		output busAddr, busWr, busRd, busWdata);
endinterface // dps_if

// ===== verilog/dps_host.sv
`timescale 1ns/100ps
// ****************************************
// port select and control, host end
// ****************************************
module dps_host import dps_pkg::*; (
	// register bus and request lines
	dps_if.host bus,
	// command port
	input wire logic cmdValid,
	input wire logic cmdWrite,
	input wire logic [ADDR_W-1:0] cmdAddr,
	input wire logic [15:0] cmdWdata,
	output logic cmdReady,
	// answer port
	output logic rspValid,
	output logic [15:0] rspData,
	output logic rspErr,
	// buffer policy per port
	input wire logic [NPORT-1:0] freezeMode,
	input wire logic [NPORT-1:0] readyIrqMode,
	// dma requests, active high
	output logic [1:0] dmaReq
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b001,
		H_WAIT = 3'b010,
		H_CHECK = 3'b100
	} dps_hstate_t;

	logic clk;
	logic rst_n;
	dps_hstate_t state_q;
	logic [15:0] shadow_q [NPORT];
	logic [15:0] expect_q;
	logic [6:0] busAddr_q;
	logic busWr_q, busRd_q;
	logic [15:0] busWdata_q;
	logic isSel, conflict;
	logic [1:0] port;
	logic [15:0] wAdj;

	assign clk = bus.clk;
	assign rst_n = bus.rst_n;
	assign bus.busAddr = busAddr_q;
	assign bus.busWr = busWr_q;
	assign bus.busRd = busRd_q;
	assign bus.busWdata = busWdata_q;

	// select writes adjusted to the software obligations
	always_comb begin
		isSel = 1'b0;
		port = 2'd0;
		conflict = 1'b0;
		for (int p = 0; p < NPORT; p++) begin
			if (cmdAddr == SEL_ADDR[p]) begin
				isSel = 1'b1;
				port = 2'(p);
			end
		end
		wAdj = cmdWdata;
		if (isSel) begin
			for (int p = 0; p < NPORT; p++) begin
				if (2'(p) != port && cmdWdata[3:0] != PIPE_NONE
					&& shadow_q[p][3:0] == cmdWdata[3:0]) conflict = 1'b1;
			end
			if (freezeMode[port]) wAdj[SEL_READ_COUNT_MODE] = 1'b0;
			// auto clear off in irq mode
			if (readyIrqMode[port]) wAdj[SEL_AUTO_CLEAR_ENABLE] = 1'b0;
			// no rewind on change or freeze
			if (cmdWdata[3:0] != shadow_q[port][3:0] || freezeMode[port]) begin
				wAdj[SEL_REW] = 1'b0;
			end
			if (cmdWdata[3:0] != shadow_q[port][3:0]) wAdj[SEL_DMA_REQUEST_ENABLE] = 1'b0;
		end
	end

	// command sequencing
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= H_IDLE;
			cmdReady <= 1'b1;
			rspValid <= 1'b0;
			rspData <= '0;
			rspErr <= 1'b0;
			busAddr_q <= '0;
			busWr_q <= 1'b0;
			busRd_q <= 1'b0;
			busWdata_q <= '0;
			expect_q <= '0;
		end else begin
			busWr_q <= 1'b0;
			busRd_q <= 1'b0;
			rspValid <= 1'b0;
			unique case (state_q)
				H_IDLE: begin
					if (cmdValid && cmdReady) begin
						busAddr_q <= cmdAddr;
						busWdata_q <= wAdj;
						rspData <= '0;
						if (!cmdWrite) begin
							busRd_q <= 1'b1;
							cmdReady <= 1'b0;
							state_q <= H_WAIT;
						end else if (isSel && conflict) begin
							rspValid <= 1'b1;
							rspErr <= 1'b1;
						end else begin
							busWr_q <= 1'b1;
							if (isSel) begin
								expect_q <= wAdj & SEL_MASK[port] & ~(16'h0001 << SEL_REW);
								cmdReady <= 1'b0;
								state_q <= H_CHECK;
							end else begin
								rspValid <= 1'b1;
								rspErr <= 1'b0;
							end
						end
					end
				end
				H_CHECK: begin
					busRd_q <= 1'b1;
					state_q <= H_WAIT;
				end
				H_WAIT: begin
					if (bus.busRvalid) begin
						rspValid <= 1'b1;
						rspData <= bus.busRdata;
						rspErr <= busWdata_q != '0 && expect_q != bus.busRdata
							&& busAddr_q == SEL_ADDR[0] | busAddr_q == SEL_ADDR[1]
							| busAddr_q == SEL_ADDR[2] ? 1'b1 : 1'b0;
						cmdReady <= 1'b1;
						state_q <= H_IDLE;
					end
				end
			endcase
		end
	end

	// shadow of each selection written
	always_ff @(posedge clk) begin
		for (int p = 0; p < NPORT; p++) begin
			if (!rst_n) begin
				shadow_q[p] <= SEL_RESET;
			end else if (busWr_q && busAddr_q == SEL_ADDR[p]) begin
				shadow_q[p] <= busWdata_q;
			end
		end
	end

	// request lines seen by the user side
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dmaReq <= 2'b00;
		end else begin
			dmaReq <= ~bus.dmaReqN;
		end
	end
endmodule // dps_host

// ===== verif/dps_checker.sv
`timescale 1ns/100ps
// ****************************************
// bus and request checks
// ****************************************
module dps_checker import dps_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register bus and requests
	input wire logic [6:0] busAddr,
	input wire logic busWr,
	input wire logic busRd,
	input wire logic [15:0] busWdata,
	input wire logic [15:0] busRdata,
	input wire logic busRvalid,
	input wire logic [1:0] dmaReqN
);
	logic [2:0][15:0] selShadow_q;
	logic [15:0] selExp;
	logic selHit;
	logic reqEn0;
	logic reqEn1;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// shadow of select words as written
	always_ff @(posedge clk) begin
		for (int i = 0; i < 3; i++) begin
			if (!rst_n) begin
				selShadow_q[i] <= SEL_RESET;
			end else if (busWr && busAddr == SEL_ADDR[i]) begin
				selShadow_q[i] <= busWdata & SEL_MASK[i];
			end
		end
	end
	// expected readback, rewind bit always zero
	always_comb begin
		selHit = 1'b0;
		selExp = 16'h0000;
		for (int i = 0; i < 3; i++) begin
			if (busAddr == SEL_ADDR[i]) begin
				selHit = 1'b1;
				selExp = selShadow_q[i] & 16'hBFFF;
			end
		end
	end
	// request may stand only with enable and pipe
	assign reqEn0 = selShadow_q[1][SEL_DMA_REQUEST_ENABLE] && selShadow_q[1][3:0] != PIPE_NONE;
	assign reqEn1 = selShadow_q[2][SEL_DMA_REQUEST_ENABLE] && selShadow_q[2][3:0] != PIPE_NONE;
	sequence s_rd(logic [6:0] a);
		busRd && busAddr == a;
	endsequence
	sequence s_ans;
		##2 busRvalid;
	endsequence
	property p_rd_answer;
		busRd |-> s_ans;
	endproperty
	property p_no_stray;
		busRvalid |-> $past(busRd, 2);
	endproperty
	property p_one_cycle;
		busRvalid |=> !busRvalid;
	endproperty
	property p_sel_back;
		busRd && selHit |-> ##2 busRdata == $past(selExp, 2);
	endproperty
	property p_rew_zero;
		s_rd(DMA0_SEL) or s_rd(DMA1_SEL) |-> ##2 !busRdata[SEL_REW];
	endproperty
	property p_ctrl_top;
		s_rd(DMA0_CTRL) or s_rd(DMA1_CTRL) |-> ##2 busRdata[15:14] == 2'b00;
	endproperty
	property p_req0;
		!dmaReqN[0] |-> $past(reqEn0);
	endproperty
	property p_req1;
		!reqEn1 [*2] |-> dmaReqN[1];
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	a_no_stray: assert property (p_no_stray) else $error("answer without read");
	a_one_cycle: assert property (p_one_cycle) else $error("answer too long");
	a_sel_back: assert property (p_sel_back) else $error("select readback wrong");
	a_rew_zero: assert property (p_rew_zero) else $error("rewind bit not zero");
	a_ctrl_top: assert property (p_ctrl_top) else $error("valid or clear reads one");
	a_req0: assert property (p_req0) else $error("port0 request not enabled");
	a_req1: assert property (p_req1) else $error("port1 request not enabled");
endmodule // dps_checker

// ===== verif/tb_top.sv
`timescale 1ns/100ps
// ****************************************
// bench top, host end facing device end
// ****************************************
module tb_top import dps_pkg::*;;
	logic clk, rst_n, rxPktValid, txValid, txReady, txTwoBytes, commitValid, commitZlp;
	logic cmdValid, cmdWrite, cmdReady, rspValid, rspErr, stall;
	logic [3:0] rxPktPipe, bufRdPipe, txPipe, commitPipe;
	logic [LEN_W-1:0] rxPktLen, commitLen;
	logic [LEN_W-2:0] bufRdAddr;
	logic [15:0] rxWord, txData, cmdWdata, rspData, lfsr, d;
	logic [NPIPE-1:0] pipeTx, pipeFreeze;
	logic [ADDR_W-1:0] cmdAddr;
	logic [NPORT-1:0] freezeMode, readyIrqMode;
	logic [1:0] dmaReq;
	logic [32:0] r;
	logic [32:0] rspQ[$];
	logic [20:0] txQ[$];
	logic [16:0] comQ[$];
	int fail_count, compares;
	// byte k of pipe p reads back as {p, k}
	assign rxWord = {bufRdPipe, bufRdAddr[2:0], 1'b1, bufRdPipe, bufRdAddr[2:0], 1'b0};
	dps_if u_dps_if (.clk(clk), .rst_n(rst_n));
	dps_device u_dps_device (.bus(u_dps_if.dev), .rxPktValid(rxPktValid),
		.rxPktPipe(rxPktPipe), .rxPktLen(rxPktLen), .rxWord(rxWord), .bufRdPipe(bufRdPipe),
		.bufRdAddr(bufRdAddr), .pipeTx(pipeTx), .pipeFreeze(pipeFreeze), .txValid(txValid),
		.txReady(txReady), .txPipe(txPipe), .txData(txData), .txTwoBytes(txTwoBytes),
		.commitValid(commitValid), .commitPipe(commitPipe), .commitLen(commitLen),
		.commitZlp(commitZlp));
	dps_host u_dps_host (.bus(u_dps_if.host), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
		.cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdReady(cmdReady), .rspValid(rspValid),
		.rspData(rspData), .rspErr(rspErr), .freezeMode(freezeMode),
		.readyIrqMode(readyIrqMode), .dmaReq(dmaReq));
	dps_checker u_dps_checker (.clk(clk), .rst_n(rst_n), .busAddr(u_dps_if.busAddr),
		.busWr(u_dps_if.busWr), .busRd(u_dps_if.busRd), .busWdata(u_dps_if.busWdata),
		.busRdata(u_dps_if.busRdata), .busRvalid(u_dps_if.busRvalid),
		.dmaReqN(u_dps_if.dmaReqN));
	// clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		if (fail_count == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic cmd(input logic w, input logic [6:0] a, input logic [15:0] wd,
		input logic [15:0] e, input logic [15:0] m, input logic er);
		int n;
		rspQ.push_back({e, m, er});
		cmdValid <= 1'b1;
		cmdWrite <= w;
		cmdAddr <= a;
		cmdWdata <= wd;
		n = 0;
		do begin @(posedge clk); n++; end while (cmdReady !== 1'b1 && n < 20);
		cmdValid <= 1'b0;
		n = 0;
		do begin @(posedge clk); n++; end while (rspValid !== 1'b1 && n < 20);
	endtask
	task automatic rd(input logic [6:0] a, input logic [15:0] e, input logic [15:0] m);
		cmd(1'b0, a, 16'h0000, e, m, 1'b0);
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] wd);
		cmd(1'b1, a, wd, 16'h0000, 16'h0000, 1'b0);
	endtask
	task automatic sw(input int i, input logic [15:0] wd, input logic [15:0] e);
		wr(SEL_ADDR[i], wd);
		rd(SEL_ADDR[i], e, 16'hFFFF);
	endtask
	task automatic pk(input logic [3:0] p, input logic [LEN_W-1:0] n);
		rxPktValid <= 1'b1;
		rxPktPipe <= p;
		rxPktLen <= n;
		@(posedge clk);
		rxPktValid <= 1'b0;
	endtask
	task automatic drain();
		int n;
		n = 0;
		while (txQ.size() != 0 && n < 200) begin
			@(posedge clk);
			n++;
		end
	endtask
	// random sink stalls, sequence restarts with reset
	always @(posedge clk) begin
		if (!rst_n) begin
			lfsr <= 16'h0047;
		end else begin
			lfsr <= nxt(lfsr);
		end
		txReady <= !stall && lfsr[0];
	end
	// answer, stream and commit monitors
	always @(posedge clk) begin
		if (rst_n === 1'b1 && rspValid === 1'b1) begin
			r = rspQ.size() ? rspQ.pop_front() : 33'h1;
			check(24'(rspData & r[16:1]), 24'(r[32:17] & r[16:1]));
			check(24'(rspErr), 24'(r[0]));
		end
		if (rst_n === 1'b1 && txValid === 1'b1 && txReady === 1'b1) begin
			check(24'({txPipe, txTwoBytes, txTwoBytes ? txData : {8'h00, txData[7:0]}}),
				24'(txQ.size() ? txQ.pop_front() : 21'h0));
		end
		if (rst_n === 1'b1 && commitValid === 1'b1) begin
			check(24'({commitPipe, commitLen, commitZlp}),
				24'(comQ.size() ? comQ.pop_front() : 17'h1));
		end
	end
	// watchdog
	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		final_report();
	end
	// main sequence
	initial begin
		{rst_n, rxPktValid, rxPktPipe, rxPktLen, cmdValid, cmdWrite, cmdAddr} = '0;
		{cmdWdata, freezeMode, readyIrqMode, stall} = '0;
		pipeTx = 9'h00F;
		pipeFreeze = 9'h000;
		fail_count = 0;
		compares = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 3; i++) begin
			rd(SEL_ADDR[i], SEL_RESET, 16'hFFFF);
			rd(CTRL_ADDR[i], 16'h0000, 16'hFFFF);
		end
		wr(7'h40, 16'hFFFF);
		rd(7'h40, 16'h0000, 16'hFFFF);
		for (int p = 1; p <= 9; p++) begin
			sw(1, 16'hB500 | 16'(p), 16'hA500 | 16'(p));
		end
		sw(1, 16'h0000, 16'h0000);
		sw(0, 16'h0005, 16'h0005);
		cmd(1'b1, DMA1_SEL, 16'h0005, 16'h0000, 16'h0000, 1'b1);
		sw(0, 16'h0000, 16'h0000);
		pk(4'h6, 12'h003);
		sw(1, 16'h0006, 16'h0006);
		for (int k = 0; k < 3; k++) begin
			rd(DMA0_DATA, 16'h0060 | 16'(k), 16'h00FF);
			rd(DMA0_CTRL, (k < 2) ? 16'h2003 : 16'h0000, 16'hFFFF);
		end
		pk(4'h7, 12'h006);
		sw(2, 16'h8507, 16'h8507);
		rd(DMA1_DATA, 16'h7071, 16'hFFFF);
		rd(DMA1_CTRL, 16'h2004, 16'hFFFF);
		sw(2, 16'hC507, 16'h8507);
		rd(DMA1_CTRL, 16'h2006, 16'hFFFF);
		rd(DMA1_DATA, 16'h7071, 16'hFFFF);
		sw(2, 16'h8400, 16'h8400);
		sw(2, 16'h8407, 16'h8407);
		rd(DMA1_DATA, 16'h7372, 16'hFFFF);
		sw(2, 16'h0000, 16'h0000);
		pk(4'h8, 12'h002);
		sw(1, 16'h0008, 16'h0008);
		sw(1, 16'h1008, 16'h1008);
		check(24'({dmaReq, u_dps_if.dmaReqN}), 24'h0006);
		rd(DMA0_DATA, 16'h0080, 16'h00FF);
		rd(DMA0_DATA, 16'h0081, 16'h00FF);
		rd(DMA0_CTRL, 16'h0000, 16'hFFFF);
		check(24'({dmaReq, u_dps_if.dmaReqN}), 24'h0003);
		sw(1, 16'h0000, 16'h0000);
		// dma1 on a frozen pipe: count mode, rewind, request, auto clear
		freezeMode <= 3'b100;
		pipeFreeze <= 9'h020;
		pk(4'h6, 12'h002);
		sw(2, 16'hE006, 16'h2006);
		sw(2, 16'h3006, 16'h3006);
		check(24'({dmaReq, u_dps_if.dmaReqN}), 24'h0009);
		rd(DMA1_DATA, 16'h0060, 16'h00FF);
		sw(2, 16'h7006, 16'h3006);
		rd(DMA1_DATA, 16'h0061, 16'h00FF);
		rd(DMA1_CTRL, 16'h0000, 16'hFFFF);
		check(24'({dmaReq, u_dps_if.dmaReqN}), 24'h0003);
		sw(2, 16'h0000, 16'h0000);
		readyIrqMode <= 3'b010;
		sw(1, 16'h2009, 16'h0009);
		readyIrqMode <= 3'b000;
		sw(1, 16'h2009, 16'h2009);
		pk(4'h9, 12'h000);
		rd(DMA0_CTRL, 16'h0000, 16'hFFFF);
		pk(4'h9, 12'h004);
		rd(DMA0_CTRL, 16'h2004, 16'hFFFF);
		wr(DMA0_CTRL, 16'h4000);
		rd(DMA0_CTRL, 16'h0000, 16'hFFFF);
		sw(1, 16'h0402, 16'h0402);
		d = lfsr;
		txQ.push_back({4'h2, 1'b1, d});
		wr(DMA0_DATA, d);
		comQ.push_back({4'h2, 12'h002, 1'b0});
		wr(DMA0_CTRL, 16'h8000);
		drain();
		comQ.push_back({4'h2, 12'h000, 1'b1});
		wr(DMA0_CTRL, 16'hC000);
		sw(1, 16'h0502, 16'h0502);
		txQ.push_back({4'h2, 1'b1, 16'h3412});
		wr(DMA0_DATA, 16'h1234);
		sw(1, 16'h0002, 16'h0002);
		txQ.push_back({4'h2, 1'b0, 16'h0055});
		wr(DMA0_DATA, 16'h0055);
		comQ.push_back({4'h2, 12'h003, 1'b0});
		wr(DMA0_CTRL, 16'h8000);
		// empty stream first: output stage plus eight entries, tenth write dropped
		drain();
		stall <= 1'b1;
		sw(1, 16'h0403, 16'h0403);
		for (int k = 0; k < 10; k++) begin
			if (k < 9) begin
				txQ.push_back({4'h3, 1'b1, 16'(k)});
			end
			wr(DMA0_DATA, 16'(k));
		end
		rd(DMA0_CTRL, 16'h0000, 16'h2000);
		stall <= 1'b0;
		drain();
		comQ.push_back({4'h3, 12'h000, 1'b1});
		wr(DMA0_CTRL, 16'hC000);
		repeat (5) @(posedge clk);
		check(24'(rspQ.size() + txQ.size() + comQ.size()), 24'h0000);
		final_report();
	end
endmodule // tb_top
